// ===== analog_comparator_control.sv
// Register and event logic around four analog comparator channels.
`default_nettype none
// Summary of operation
// - Four independent channels, each with enable, source, irq, polarity.
// - A channel is powered only while its enable bit is one.
// - Source bit 0 uses internal threshold, 1 uses external threshold.
// - All four channels share one common external threshold.
// - An 8-bit code drives the threshold converter, 256 steps.
// - Polarity bit 0 passes the output, 1 inverts it.
// - CPU reads each comparator's present level through a register.
// - Every rising or falling output edge can request an interrupt.
// - An edge is forwarded only while its interrupt enable is set.
// - A/B configuration register is read/write, resets to zero, A high.
// - Threshold register code 00 is lowest, FF is highest threshold.
module analog_comparator_control #(
   parameter int NUM_CH = comparator_pkg::NUM_CH
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [comparator_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [comparator_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [comparator_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [comparator_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   input wire logic [NUM_CH-1:0] cmp_raw,
   output logic [NUM_CH-1:0] cmp_power_on,
   output logic [NUM_CH-1:0] cmp_use_ext,
   output logic [comparator_pkg::CODE_W-1:0] threshold_code,
   output logic [NUM_CH-1:0] cmp_event
);
   // ==========================================================
   // Elaboration check
   // The register layout holds exactly four nibbles of channel fields.
   if (NUM_CH != comparator_pkg::NUM_CH)
   begin : g_bad_num_ch
      $error("analog_comparator_control supports exactly four channels");
   end

   // ==========================================================
   // Declarations
   logic [7:0] ab_r, cd_r, wbyte_r;
   logic [comparator_pkg::CODE_W-1:0] thr_r;
   logic [comparator_pkg::CFG_ALL_W-1:0] cfg_all;
   logic awready_r, wready_r, bvalid_r, wlane_r, do_write;
   logic arready_r, rvalid_r, rd_hit, wr_hit;
   logic [1:0] bresp_r, rresp_r;
   logic [comparator_pkg::ADDR_W-1:0] waddr_r;
   logic [comparator_pkg::DATA_W-1:0] rdata_r, rd_word;
   logic [NUM_CH-1:0] sync1_r, sync2_r, level_r;
   logic [NUM_CH-1:0] power_r, use_ext_r, event_r;
   logic [NUM_CH-1:0] ch_on, ch_src, ch_irq, ch_inv;

   // Channel A sits in the top nibble, channel D in the bottom one.
   assign cfg_all = {ab_r, cd_r};

   // One clock covers every check in this block; the reset disables all but a_config_reset.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // Write channel
   // Address and data are parked independently, so either may come first.
   assign do_write = !awready_r && !wready_r && !bvalid_r;

   // Address and data acceptance, released again once the answer is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         waddr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
      end
      else
      begin
         if (awvalid && awready_r)
         begin
            awready_r <= 1'b0;
            waddr_r <= awaddr;
         end
         if (wvalid && wready_r)
         begin
            wready_r <= 1'b0;
            wbyte_r <= wdata[7:0];
            wlane_r <= wstrb[0];
         end
         if (bvalid_r && bready)
         begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Write decode; the level register is read-only and ignores writes.
   always_comb
   begin
      case (waddr_r[comparator_pkg::ADDR_W-1:2])
         comparator_pkg::AB_CONFIG_ADDR[15:2]: wr_hit = 1'b1;
         comparator_pkg::CD_CONFIG_ADDR[15:2]: wr_hit = 1'b1;
         comparator_pkg::THRESH_ADDR[15:2]: wr_hit = 1'b1;
         comparator_pkg::LEVEL_ADDR[15:2]: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response, one cycle after both halves are held.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= comparator_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? comparator_pkg::RESP_OKAY
                           : comparator_pkg::RESP_SLVERR;
      end
      else if (bvalid_r && bready)
      begin
         bvalid_r <= 1'b0;
      end
   end

   // Configuration storage; only byte lane 0 carries register data.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ab_r <= comparator_pkg::AB_CONFIG_RESET;
         cd_r <= comparator_pkg::CD_CONFIG_RESET;
         thr_r <= comparator_pkg::THRESH_RESET;
      end
      else if (do_write && wlane_r)
      begin
         if (waddr_r[15:2] == comparator_pkg::AB_CONFIG_ADDR[15:2])
         begin
            ab_r <= wbyte_r;
         end
         if (waddr_r[15:2] == comparator_pkg::CD_CONFIG_ADDR[15:2])
         begin
            cd_r <= wbyte_r;
         end
         if (waddr_r[15:2] == comparator_pkg::THRESH_ADDR[15:2])
         begin
            thr_r <= wbyte_r;
         end
      end
   end

   // ==========================================================
   // Read channel
   // The level word is the synchronised level, so a read adds no latch.
   always_comb
   begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (araddr[comparator_pkg::ADDR_W-1:2])
         comparator_pkg::AB_CONFIG_ADDR[15:2]: rd_word[7:0] = ab_r;
         comparator_pkg::CD_CONFIG_ADDR[15:2]: rd_word[7:0] = cd_r;
         comparator_pkg::THRESH_ADDR[15:2]: rd_word[7:0] = thr_r;
         comparator_pkg::LEVEL_ADDR[15:2]: rd_word[NUM_CH-1:0] = level_r;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read answer one cycle after the address is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= comparator_pkg::RESP_OKAY;
      end
      else if (arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? comparator_pkg::RESP_OKAY
                           : comparator_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && rready)
      begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // ==========================================================
   // Comparator channels
   // Two-stage synchroniser; only the second stage feeds any logic.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= cmp_raw;
         sync2_r <= sync1_r;
      end
   end

   for (genvar i = 0; i < NUM_CH; i++)
   begin : g_ch
      localparam int TOP = comparator_pkg::CFG_ALL_W - 1 -
                           comparator_pkg::NIBBLE * i;
      assign ch_on[i] = cfg_all[TOP - 3 + comparator_pkg::FLD_ON];
      assign ch_src[i] = cfg_all[TOP - 3 + comparator_pkg::FLD_SRC];
      assign ch_irq[i] = cfg_all[TOP - 3 + comparator_pkg::FLD_IRQ];
      assign ch_inv[i] = cfg_all[TOP - 3 + comparator_pkg::FLD_INV];

      // Power, source and event per channel. Flipping the polarity bit
      // flips the level too and is seen as an edge; software should mask
      // the interrupt while changing it.
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            power_r[i] <= 1'b0;
            use_ext_r[i] <= 1'b0;
            level_r[i] <= 1'b0;
            event_r[i] <= 1'b0;
         end
         else
         begin
            power_r[i] <= ch_on[i];
            use_ext_r[i] <= ch_src[i];
            level_r[i] <= sync2_r[i] ^ ch_inv[i];
            event_r[i] <= ch_irq[i] && ch_on[i] &&
                          ((sync2_r[i] ^ ch_inv[i]) != level_r[i]);
         end
      end

      a_power_follows: assert property
         ($rose(ch_on[i]) |=> power_r[i])
         else $error("channel not powered after enable");
      a_power_off_hold: assert property
         (!ch_on[i] [*2] |-> !power_r[i])
         else $error("channel powered while disabled");
      a_source_select: assert property
         (use_ext_r[i] == $past(ch_src[i]))
         else $error("threshold source does not follow select bit");
      a_polarity_level: assert property
         (level_r[i] == $past(sync2_r[i] ^ ch_inv[i]))
         else $error("level does not follow polarity");
      a_event_edge: assert property
         (event_r[i] |-> $past(ch_irq[i]) && $past(level_r[i]) != level_r[i])
         else $error("event without enabled edge");
      a_event_masked: assert property
         ($past(!ch_irq[i]) |-> !event_r[i])
         else $error("event raised while interrupt disabled");
      a_sync_depth: assert property
         ($changed(cmp_raw[i]) ##1 $stable(cmp_raw[i]) |->
          sync2_r[i] == $past(cmp_raw[i], 2) ##1
          sync2_r[i] == $past(cmp_raw[i], 1))
         else $error("synchroniser depth wrong");
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         threshold_code <= comparator_pkg::THRESH_RESET;
      end
      else
      begin
         threshold_code <= thr_r;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign cmp_power_on = power_r;
   assign cmp_use_ext = use_ext_r;
   assign cmp_event = event_r;

   // ==========================================================
   // Checks
   a_config_reset: assert property (disable iff (1'b0)
      $past(!aresetn) |-> ab_r == comparator_pkg::AB_CONFIG_RESET &&
      cd_r == comparator_pkg::CD_CONFIG_RESET &&
      thr_r == comparator_pkg::THRESH_RESET)
      else $error("configuration not cleared by reset");
   a_code_output: assert property
      (threshold_code == $past(thr_r))
      else $error("threshold code does not follow register");
   a_write_answer: assert property
      (do_write |=> bvalid_r ##0
       (bresp_r == comparator_pkg::RESP_OKAY) == $past(wr_hit))
      else $error("write answer missing or wrong");
   a_level_read: assert property
      (arvalid && arready_r &&
       araddr[15:2] == comparator_pkg::LEVEL_ADDR[15:2]
       |=> rvalid_r && rdata_r[NUM_CH-1:0] == $past(level_r))
      else $error("level read does not show present level");
endmodule : analog_comparator_control
`default_nettype wire

// ===== analog_comparator_control_tb.sv
// Self-checking bench for the analog comparator control block.
`default_nettype none
module analog_comparator_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [15:0] a; logic [31:0] d, q; logic [1:0] s;} row_type;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, pin_level, q;
   logic [3:0] wstrb, cmp_raw, cmp_power_on, cmp_use_ext, cmp_event;
   logic [1:0] bresp, rresp, s;
   logic [7:0] threshold_code, ext_level;
   logic [7:0] ev [4];
   int miscompares, check_count, cycles;
   row_type rows [8];
   analog_comparator_control u_analog_comparator_control (.aclk(aclk),
      .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .cmp_raw(cmp_raw), .cmp_power_on(cmp_power_on),
      .cmp_use_ext(cmp_use_ext), .threshold_code(threshold_code),
      .cmp_event(cmp_event));
   analog_comparator_model u_analog_comparator_model (
      .cmp_power_on(cmp_power_on), .cmp_use_ext(cmp_use_ext),
      .threshold_code(threshold_code), .pin_level(pin_level),
      .ext_level(ext_level), .cmp_raw(cmp_raw));
   // ==========================================================
   // Clock, event counters and hang guard
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // Events are one-cycle pulses, so they are tallied on every rising edge.
   always @(posedge aclk)
   begin
      for (int i = 0; i < 4; i++)
         ev[i] <= aresetn ? ev[i] + 8'(cmp_event[i]) : 8'h00;
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         summarize();
      end
   end
   // ==========================================================
   // Bus tasks and checks
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_d, w_d, b_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b0;
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!b_d)
      begin
         @(posedge aclk);
         if (bvalid && aw_d && w_d)
         begin
            b_d = 1'b1;
            r = bresp;
            bready <= 1'b0;
         end
         if (awready && !aw_d)
         begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_d)
         begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic a_d, done;
      a_d = 1'b0;
      done = 1'b0;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (rvalid && a_d)
         begin
            done = 1'b1;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
         if (arready && !a_d)
         begin
            a_d = 1'b1;
            arvalid <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask : rd
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Pins change, then the sync and level stages settle before reading.
   task automatic level(input logic [31:0] p, input logic [31:0] exp);
      pin_level <= p;
      repeat (5) @(posedge aclk);
      rd(comparator_pkg::LEVEL_ADDR, q, s);
      check(q, exp);
   endtask : level
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   // ==========================================================
   // Main sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
      awaddr <= 16'h0000;
      araddr <= 16'h0000;
      wdata <= 32'h0;
      wstrb <= 4'hF;
      pin_level <= 32'h0;
      ext_level <= 8'h00;
      rows = '{'{16'hA030, 32'h5A, 32'h5A, 2'h0},
         '{16'hA030, 32'hFFFFFF0F, 32'h0F, 2'h0},
         '{16'hA034, 32'hA5, 32'hA5, 2'h0}, '{16'hA038, 32'hFF, 32'hFF, 2'h0},
         '{16'hA040, 32'h77, 32'h0, 2'h2}, '{16'hA030, 32'h0, 32'h0, 2'h0},
         '{16'hA034, 32'h0, 32'h0, 2'h0}, '{16'hA03C, 32'hFF, 32'h0, 2'h0}};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // Each row writes, reads back, and checks both responses.
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d, s);
         check(32'(s), 32'(rows[i].s));
         rd(rows[i].a, q, s);
         check(q, rows[i].q);
         check(32'(s), 32'(rows[i].s));
      end
      $display("test register rows done");
      // Mid-run reset must clear the configuration again.
      wr(comparator_pkg::AB_CONFIG_ADDR, 32'hFF, s);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check(32'(cmp_power_on), 32'h0);
      rd(comparator_pkg::AB_CONFIG_ADDR, q, s);
      check(q, 32'h0);
      $display("test reset done");
      // Channel A on internal threshold with its interrupt enabled.
      wr(comparator_pkg::THRESH_ADDR, 32'h80, s);
      wr(comparator_pkg::AB_CONFIG_ADDR, 32'hA0, s);
      check(32'({cmp_power_on, cmp_use_ext}), 32'h10);
      check(32'(threshold_code), 32'h80);
      // A write with byte lane 0 off is answered but stores nothing.
      wstrb <= 4'hE;
      wr(comparator_pkg::THRESH_ADDR, 32'h11, s);
      wstrb <= 4'hF;
      check(32'(s), 32'h0);
      rd(comparator_pkg::THRESH_ADDR, q, s);
      check(q, 32'h80);
      repeat (200) @(posedge aclk);
      level(32'h90, 32'h1);
      check(32'(ev[0]), 32'h1);
      level(32'h80, 32'h0);
      check(32'(ev[0]), 32'h2);
      wr(comparator_pkg::AB_CONFIG_ADDR, 32'hB0, s);
      level(32'h80, 32'h1);
      check(32'(ev[0]), 32'h3);
      wr(comparator_pkg::AB_CONFIG_ADDR, 32'h90, s);
      level(32'h90, 32'h0);
      check(32'(ev[0]), 32'h3);
      $display("test channel a done");
      // Channels B, C and D on the shared external threshold.
      ext_level <= 8'h40;
      wr(comparator_pkg::AB_CONFIG_ADDR, 32'h0C, s);
      wr(comparator_pkg::CD_CONFIG_ADDR, 32'hCC, s);
      check(32'({cmp_power_on, cmp_use_ext}), 32'hEE);
      repeat (200) @(posedge aclk);
      level(32'h50505050, 32'hE);
      ext_level <= 8'h60;
      level(32'h50505050, 32'h0);
      check(32'(ev[1] + ev[2] + ev[3]), 32'h0);
      $display("test external threshold done");
      summarize();
   end
endmodule : analog_comparator_control_tb
`default_nettype wire

// ===== analog_comparator_model.sv
// Behavioural model of four analog comparators and their threshold source.
`default_nettype none
module analog_comparator_model (
   input wire logic [3:0] cmp_power_on,
   input wire logic [3:0] cmp_use_ext,
   input wire logic [7:0] threshold_code,
   input wire logic [31:0] pin_level,
   input wire logic [7:0] ext_level,
   output logic [3:0] cmp_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Comparison
   // Pin levels are byte codes on the same scale as the threshold code.
   // An unpowered channel has no bias, so its output rests low.
   // Each pin is read as an analog level only, with no digital driver on it.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (!cmp_power_on[i])
            cmp_raw[i] = 1'b0;
         else if (cmp_use_ext[i])
            cmp_raw[i] = pin_level[i*8+:8] > ext_level;
         else
            cmp_raw[i] = pin_level[i*8+:8] > threshold_code;
      end
   end
endmodule : analog_comparator_model
`default_nettype wire

// ===== comparator_pkg.sv
// Constants shared by the analog comparator control logic.
`default_nettype none
package comparator_pkg;
   // ==========================================================
   // Bus and register layout
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 4;
   localparam int CODE_W = 8;
   localparam int CFG_W = 8;
   localparam int NIBBLE = 4;
   localparam int CFG_ALL_W = 16;
   localparam logic [15:0] AB_CONFIG_ADDR = 16'hA030;
   localparam logic [15:0] CD_CONFIG_ADDR = 16'hA034;
   localparam logic [15:0] THRESH_ADDR = 16'hA038;
   localparam logic [15:0] LEVEL_ADDR = 16'hA03C;
   // ==========================================================
   // Reset values
   localparam logic [7:0] AB_CONFIG_RESET = 8'h00;
   localparam logic [7:0] CD_CONFIG_RESET = 8'h00;
   localparam logic [7:0] THRESH_RESET = 8'h00;
   // ==========================================================
   // Field positions inside one channel nibble
   localparam int FLD_ON = 3;
   localparam int FLD_SRC = 2;
   localparam int FLD_IRQ = 1;
   localparam int FLD_INV = 0;
   // ==========================================================
   // AXI4-Lite response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : comparator_pkg
`default_nettype wire

// ===== placeholder_none.sv
// Empty compilation unit kept intentionally minimal.
`default_nettype none
`default_nettype wire
